// file: test/sleep_state_entry_control_test.sv
/*
  self-checking bench for the sleep-entry controller, driving its apb port.
  assumes the package, the config header and the wake source model.
*/
`timescale 1ns/1ns
`include "sslp_cfg.svh"

module sleep_state_entry_control_test;
  import sslp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, arm = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, wake, cpu_stop, plane_off, hib;
  logic [2:0] code_a, code_b;
  int error_cnt = 0, compares = 0, n;

  // 125 MHz clock
  always #4 clk = ~clk;

  sslp_ctrl uut (.REF_CLK(clk), .ARST_N(rst_n), .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .WAKE_EVENT(wake), .CPU_STOP(cpu_stop), .PLANE_OFF(plane_off),
    .SLEEP_CODE_A(code_a), .SLEEP_CODE_B(code_b), .FW_HIB_REQ(hib));

  sslp_wake_src wsrc (.clk(clk), .arm(arm), .plane_off(plane_off), .cpu_stop(cpu_stop), .wake(wake));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    // a transfer that never saw pready counts as a mismatch
    if (k >= 50) chk(pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // full sleep entry and wake for one type code
  task automatic sleep(input logic [2:0] t, input logic [7:0] a);
    apb(1'b1, a, {18'h0, 1'b1, t, 10'h0});
    #1 chk({plane_off, cpu_stop, (a == `SSLP_OFF_CTRL_A) ? code_a : code_b}, {1'b0, 1'b1, t});
    repeat (3) @(posedge clk);
    #1 chk(plane_off, 1'b0);
    @(posedge clk);
    #1 chk(plane_off, 1'b1);
    apb(1'b0, `SSLP_OFF_STATUS, 32'h0);
    chk(r, 32'h11);
    @(posedge clk);
    arm <= 1'b1;
    n = 0;
    for (int i = 0; i < 200 && cpu_stop === 1'b1; i++) begin
      @(posedge clk);
      #1 if (plane_off === 1'b0 && cpu_stop === 1'b1) n++;
    end
    chk(n, 8);
    @(posedge clk);
    arm <= 1'b0;
    apb(1'b1, `SSLP_OFF_STATUS, 32'h1);
    apb(1'b0, `SSLP_OFF_STATUS, 32'h0);
    chk(r, 32'h4);
    $display("sleep code %0d done", t);
  endtask

  task automatic finish_test;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #60000 error_cnt++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `SSLP_OFF_CTRL_A, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, `SSLP_OFF_HIBVAL, 32'h0);
    chk(r, 32'h1E00);
    $display("reset values done");
    // type-only writes start nothing
    apb(1'b1, `SSLP_OFF_CTRL_A, 32'h1C00);
    apb(1'b1, `SSLP_OFF_CTRL_B, 32'h1400);
    #1 chk({cpu_stop, code_a, code_b}, {1'b0, 3'h7, 3'h5});
    apb(1'b1, `SSLP_OFF_CTRL_A, 32'h0C00);
    #1 chk({cpu_stop, code_a}, {1'b0, 3'h3});
    apb(1'b0, `SSLP_OFF_CTRL_A, 32'h0);
    chk(r, 32'h0C00);
    $display("type writes done");
    // the last code starts from group two, which shares one start decode with group one
    for (int t = 1; t <= 4; t++) sleep(3'(t), (t == 4) ? `SSLP_OFF_CTRL_B : `SSLP_OFF_CTRL_A);
    // unsupported code is refused
    apb(1'b1, `SSLP_OFF_CTRL_A, 32'h2000);
    #1 chk(cpu_stop, 1'b0);
    apb(1'b0, `SSLP_OFF_STATUS, 32'h0);
    chk(r, 32'h6);
    apb(1'b1, `SSLP_OFF_STATUS, 32'h2);
    $display("refused code done");
    // firmware hibernate through the command port
    apb(1'b1, `SSLP_OFF_HIBVAL, 32'h1E5A);
    apb(1'b1, `SSLP_OFF_SMCMD, 32'h33);
    #1 chk(hib, 1'b0);
    apb(1'b1, `SSLP_OFF_SMCMD, 32'h5A);
    #1 chk({hib, cpu_stop}, 2'b10);
    @(posedge clk);
    #1 chk({hib, cpu_stop}, 2'b00);
    $display("hibernate request done");
    // unmapped address, then a read stalled by the clock enable
    apb(1'b0, 8'h20, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    fork
      apb(1'b0, `SSLP_OFF_HIBVAL, 32'h0);
      begin
        repeat (2) @(posedge clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
      end
    join
    chk(r, 32'h1E5A);
    $display("bus cases done");
    finish_test();
  end
endmodule // sleep_state_entry_control_test

// file: test/sslp_wake_src.sv
/*
  wake source model standing outside the controller: once armed and the planes
  are off it raises the wake level, and drops it when the processor runs again.
  assumes the bench arms it and that outputs change on the rising edge.
*/
`timescale 1ns/1ns

module sslp_wake_src #(
  parameter int DELAY = 6 // cycles asleep before the event
) (
  input wire logic clk, // system clock
  input wire logic arm, // wake event enabled by software
  input wire logic plane_off, // planes off from the device
  input wire logic cpu_stop, // processor held by the device
  output logic wake // wake level to the device
);
  int cnt = 0;
  initial wake = 1'b0;
  // only an enabled source may wake the sleeping system
  always @(posedge clk) begin
    cnt <= (plane_off && arm) ? cnt + 1 : 0;
    if (cnt == DELAY) begin
      wake <= 1'b1;
    end else if (!cpu_stop) begin
      wake <= 1'b0;
    end
  end
endmodule // sslp_wake_src

// file: verilog/sslp_cfg.svh
/*
  constants of the sleep-entry controller: register offsets, field positions,
  reset values and sequencing times.
  assumes inclusion by bare name from the package and the test bench.
*/
`ifndef SSLP_CFG_SVH
`define SSLP_CFG_SVH

// apb register byte offsets
`define SSLP_OFF_CTRL_A 8'h00
`define SSLP_OFF_CTRL_B 8'h04
`define SSLP_OFF_STATUS 8'h08
`define SSLP_OFF_SMCMD 8'h0C
`define SSLP_OFF_HIBVAL 8'h10

// control register group fields
`define SSLP_TYPE_LSB 10
`define SSLP_TYPE_MSB 12
`define SSLP_START_BIT 13

// status register fields
`define SSLP_ST_WAKE_BIT 0
`define SSLP_ST_BADTYPE_BIT 1
`define SSLP_ST_STATE_LSB 2
`define SSLP_ST_STATE_MSB 5

// reset values
`define SSLP_TYPE_RST 3'h0
`define SSLP_HIBVAL_RST 8'h00
`define SSLP_SUPPORT_RST 8'h1E

// sequencing times in ns, clock period in ns
`define SSLP_CLK_NS 8
`define SSLP_HALT_NS 32
`define SSLP_WAKE_NS 64
`define SSLP_HALT_CYC ((`SSLP_HALT_NS + `SSLP_CLK_NS - 1) / `SSLP_CLK_NS)
`define SSLP_WAKE_CYC ((`SSLP_WAKE_NS + `SSLP_CLK_NS - 1) / `SSLP_CLK_NS)

`endif

// file: verilog/sslp_ctrl.sv
/*
  sleep-entry controller: two control register groups with sleep type codes and a
  sleep start bit, hardware sequencing into sleep, wake status, and a system
  management command port for firmware hibernate entry, all behind an apb slave.
  assumes a 125 MHz REF_CLK, an asynchronous WAKE_EVENT pin, and an apb master.
*/
`timescale 1ns/1ns

// What this block does
// - 3-bit sleep type field per group plus separate one-bit sleep start control.
// - setting sleep start begins sequencing into the state the type field encodes.
// - groups one and two each hold their own 3-bit sleep type code.
// - wake status bit is set by hardware while sleeping.
// - processor is held stopped in every sleeping state, never merely slowed.
// - at least one sleeping state; each supported state has its own code.
// - only the sleep start bit triggers power-plane sequencing, nothing else.
module sslp_ctrl
  import sslp_pkg::*;
(
  input wire logic REF_CLK, // 125 MHz clock
  input wire logic ARST_N, // asynchronous reset, low active
  input wire logic CLK_EN, // clock enable, freezes all state when low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error on unmapped address
  input wire logic WAKE_EVENT, // enabled wake event pin, asynchronous
  output logic CPU_STOP, // processor stop request, high while not working
  output logic PLANE_OFF, // power planes off request
  output logic [2:0] SLEEP_CODE_A, // group one sleep type in force
  output logic [2:0] SLEEP_CODE_B, // group two sleep type in force
  output logic FW_HIB_REQ // one-cycle firmware hibernate request
);
  localparam int HALT_N = `SSLP_HALT_CYC;
  localparam int WAKE_N = `SSLP_WAKE_CYC;

  sslp_state_t state_reg;
  sslp_state_t state_next;
  sslp_cnt_t cnt_reg;
  sslp_type_t type_a_reg;
  sslp_type_t type_b_reg;
  logic [7:0] hibval_reg;
  logic [7:0] support_reg;
  logic wake_sts_reg;
  logic bad_type_reg;
  logic hib_req_reg;
  logic [31:0] prdata_reg;
  logic wake_sync;
  logic wr_acc;
  logic setup;
  logic sel_a;
  logic sel_b;
  logic sel_st;
  logic sel_cmd;
  logic sel_hv;
  logic mapped;
  logic start_req;
  logic type_ok;
  sslp_type_t start_type;
  logic enter_sleep;

  // wake pin crossing
  sslp_sync u_wake_sync (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .ce(CLK_EN),
    .d_in(WAKE_EVENT),
    .q_out(wake_sync)
  );

  // apb decode; the slave answers in the first access cycle unless frozen
  assign sel_a = (PADDR == `SSLP_OFF_CTRL_A);
  assign sel_b = (PADDR == `SSLP_OFF_CTRL_B);
  assign sel_st = (PADDR == `SSLP_OFF_STATUS);
  assign sel_cmd = (PADDR == `SSLP_OFF_SMCMD);
  assign sel_hv = (PADDR == `SSLP_OFF_HIBVAL);
  assign mapped = sel_a | sel_b | sel_st | sel_cmd | sel_hv;
  assign setup = PSEL & ~PENABLE;
  assign wr_acc = PSEL & PENABLE & PWRITE & CLK_EN & mapped;
  assign PREADY = CLK_EN;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign PRDATA = prdata_reg;

  // type and start arrive in one write to a control group; new code is used at once
  assign start_req = wr_acc & (sel_a | sel_b) & PWDATA[`SSLP_START_BIT];
  assign start_type = PWDATA[`SSLP_TYPE_MSB:`SSLP_TYPE_LSB];
  assign type_ok = support_reg[start_type];
  assign enter_sleep = (state_reg == SSLP_HALT) && (cnt_reg == sslp_cnt_t'(HALT_N - 1));

  // control group registers, one type field each
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      type_a_reg <= `SSLP_TYPE_RST;
      type_b_reg <= `SSLP_TYPE_RST;
    end else if (wr_acc) begin
      if (sel_a) begin
        type_a_reg <= start_type;
      end
      if (sel_b) begin
        type_b_reg <= start_type;
      end
    end
  end

  // hibernate request value and supported-code mask
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hibval_reg <= `SSLP_HIBVAL_RST;
      support_reg <= `SSLP_SUPPORT_RST;
    end else if (wr_acc && sel_hv) begin
      hibval_reg <= PWDATA[7:0];
      support_reg <= PWDATA[15:8];
    end
  end

  // command port: a matching byte raises a one-cycle firmware request
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hib_req_reg <= 1'b0;
    end else if (CLK_EN) begin
      hib_req_reg <= wr_acc & sel_cmd & (PWDATA[7:0] == hibval_reg);
    end
  end
  assign FW_HIB_REQ = hib_req_reg;

  // sticky status flags; a hardware set beats a software clear in the same cycle
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wake_sts_reg <= 1'b0;
      bad_type_reg <= 1'b0;
    end else if (CLK_EN) begin
      if (enter_sleep || state_reg == SSLP_SLEEP) begin
        wake_sts_reg <= 1'b1;
      end else if (wr_acc && sel_st && PWDATA[`SSLP_ST_WAKE_BIT]) begin
        wake_sts_reg <= 1'b0;
      end
      if (start_req && state_reg == SSLP_IDLE && !type_ok) begin
        bad_type_reg <= 1'b1;
      end else if (wr_acc && sel_st && PWDATA[`SSLP_ST_BADTYPE_BIT]) begin
        bad_type_reg <= 1'b0;
      end
    end
  end

  // read data captured in the setup cycle; start bit always reads zero
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_reg <= 32'h00000000;
    end else if (CLK_EN && setup) begin
      prdata_reg <= 32'h00000000;
      if (sel_a) begin
        prdata_reg[`SSLP_TYPE_MSB:`SSLP_TYPE_LSB] <= type_a_reg;
      end
      if (sel_b) begin
        prdata_reg[`SSLP_TYPE_MSB:`SSLP_TYPE_LSB] <= type_b_reg;
      end
      if (sel_st) begin
        prdata_reg[`SSLP_ST_WAKE_BIT] <= wake_sts_reg;
        prdata_reg[`SSLP_ST_BADTYPE_BIT] <= bad_type_reg;
        prdata_reg[`SSLP_ST_STATE_MSB:`SSLP_ST_STATE_LSB] <= state_reg;
      end
      if (sel_hv) begin
        prdata_reg[15:0] <= {support_reg, hibval_reg};
      end
    end
  end

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SSLP_IDLE: begin
        if (start_req && type_ok) begin
          state_next = SSLP_HALT;
        end
      end
      SSLP_HALT: begin
        if (enter_sleep) begin
          state_next = SSLP_SLEEP;
        end
      end
      SSLP_SLEEP: begin
        if (wake_sync) begin
          state_next = SSLP_WAKE;
        end
      end
      SSLP_WAKE: begin
        if (cnt_reg == sslp_cnt_t'(WAKE_N - 1)) begin
          state_next = SSLP_IDLE;
        end
      end
      default: begin
        state_next = SSLP_IDLE;
      end
    endcase
  end

  // sequencer state and dwell counter
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= SSLP_IDLE;
      cnt_reg <= 4'h0;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        cnt_reg <= 4'h0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  // processor held stopped through the whole sleep, planes off only in sleep
  assign CPU_STOP = (state_reg != SSLP_IDLE);
  assign PLANE_OFF = (state_reg == SSLP_SLEEP);
  assign SLEEP_CODE_A = type_a_reg;
  assign SLEEP_CODE_B = type_b_reg;

  default clocking cb @(posedge REF_CLK iff CLK_EN); endclocking
  default disable iff (!ARST_N);

  sequence s_halt_run;
    (state_reg == SSLP_HALT) [*4];
  endsequence

  sequence s_wake_run;
    (state_reg == SSLP_WAKE) [*8];
  endsequence

  a_start_to_halt: assert property (
    (state_reg == SSLP_IDLE && start_req && type_ok) |=> s_halt_run ##1 (state_reg == SSLP_SLEEP))
    else $error("accepted start did not lead through halt into sleep");
  a_type_only_idle: assert property (
    (state_reg == SSLP_IDLE && wr_acc && (sel_a || sel_b) && !PWDATA[`SSLP_START_BIT]) |=> state_reg == SSLP_IDLE)
    else $error("write without start bit started a sequence");
  a_bad_type_flag: assert property (
    (state_reg == SSLP_IDLE && start_req && !type_ok) |=> (state_reg == SSLP_IDLE && bad_type_reg))
    else $error("unsupported sleep type was not refused");
  a_cpu_held: assert property (
    (state_reg == SSLP_SLEEP) |-> (CPU_STOP && $past(CPU_STOP)))
    else $error("processor not held stopped around sleep");
  a_wake_status: assert property (
    (state_reg == SSLP_SLEEP) |-> wake_sts_reg)
    else $error("wake status clear while sleeping");
  a_wake_exit: assert property (
    (state_reg == SSLP_SLEEP && wake_sync) |=> s_wake_run ##1 (state_reg == SSLP_IDLE && !CPU_STOP))
    else $error("wake did not return to working in time");
  a_start_reads_zero: assert property (
    (PSEL && PENABLE && !PWRITE) |-> !PRDATA[`SSLP_START_BIT])
    else $error("sleep start bit read back as one");
  a_plane_cause: assert property (
    $rose(PLANE_OFF) |-> $past(state_reg == SSLP_HALT))
    else $error("power planes switched without a start sequence");
  a_type_store: assert property (
    (wr_acc && sel_b) |=> (SLEEP_CODE_B == $past(start_type) && $stable(SLEEP_CODE_A)))
    else $error("group two type not stored independently");
endmodule // sslp_ctrl

// file: verilog/sslp_pkg.sv
/*
  types of the sleep-entry controller.
  assumes sslp_cfg.svh on the include path.
*/
`include "sslp_cfg.svh"

package sslp_pkg;
  // one-hot sequencer states
  typedef enum logic [3:0] {
    SSLP_IDLE = 4'h1,
    SSLP_HALT = 4'h2,
    SSLP_SLEEP = 4'h4,
    SSLP_WAKE = 4'h8
  } sslp_state_t;
  typedef logic [2:0] sslp_type_t;
  typedef logic [3:0] sslp_cnt_t;
endpackage

// file: verilog/sslp_sync.sv
/*
  three-flop synchroniser with agreement filter for one external level.
  assumes a single clock, asynchronous active-low reset, and a clock enable.
*/
`timescale 1ns/1ns

module sslp_sync (
  input wire logic clk, // sampling clock
  input wire logic arst_n, // asynchronous reset, low active
  input wire logic ce, // clock enable
  input wire logic d_in, // asynchronous level
  output logic q_out // filtered synchronous level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // chain of three flops; the value moves only when stages two and three agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_out <= 1'b0;
    end else if (ce) begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q_out <= s3_reg;
      end
    end
  end
endmodule // sslp_sync
